// ---- rtl/gpa_gpio_port.sv ----
// gpio port: 32 pins, each a general input, general output or alternate
`timescale 1ns/1ps
`include "gpa_defs.svh"

module gpa_gpio_port (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire gpa_pkg::gpa_cfg_req_t cfg_req,
	output      gpa_pkg::gpa_cfg_rsp_t cfg_rsp,
	input  wire logic [31:0]          pin_in,
	output      gpa_pkg::gpa_pad_t     pad,
	input  wire logic                 event_out_n,
	input  wire logic [15:1]          downstream_port_reset_out_n,
	output      logic [8:0]           expander_irq_in_n
);

	// register select decode
	function automatic logic sel_hit(input logic [1:0] sel,
	                                 input logic [1:0] reg_sel);
		sel_hit = (sel == reg_sel);
	endfunction : sel_hit

	logic [31:0]           func_q;
	logic [31:0]           dir_q;
	logic [31:0]           latch_q;
	logic [31:0]           sync1_q;
	logic [31:0]           sync2_q;
	logic [31:0]           level_q;
	logic [`GPA_DIV_W-1:0] div_q;
	logic [`GPA_DIV_W-1:0] div_d;
	gpa_pkg::gpa_cfg_rsp_t rsp_q;
	gpa_pkg::gpa_pad_t     pad_q;
	logic [8:0]            irq_q;

	// next values built field by field, so they are nets
	wire gpa_pkg::gpa_cfg_rsp_t rsp_d;
	wire gpa_pkg::gpa_pad_t     pad_d;
	wire logic [8:0]            irq_d;

	wire logic        wr_func;
	wire logic        wr_dir;
	wire logic        wr_data;
	wire logic        sample_en;
	wire logic [31:0] gp_out_sel;
	wire logic [31:0] alt_drive;
	wire logic [31:0] rd_mux;

	// config space decode of the three pin registers
	assign wr_func = cfg_req.wr && sel_hit(cfg_req.sel, `GPA_REG_FUNC);
	assign wr_dir  = cfg_req.wr && sel_hit(cfg_req.sel, `GPA_REG_DIR);
	assign wr_data = cfg_req.wr && sel_hit(cfg_req.sel, `GPA_REG_DATA);

	// read mux; data reads return pin levels, an unused select reads zero
	assign rd_mux = sel_hit(cfg_req.sel, `GPA_REG_FUNC) ? func_q :
	                sel_hit(cfg_req.sel, `GPA_REG_DIR)  ? dir_q  :
	                sel_hit(cfg_req.sel, `GPA_REG_DATA) ? level_q :
	                `GPA_ZERO;
	assign rsp_d.valid = cfg_req.rd;
	assign rsp_d.rdata = cfg_req.rd ? rd_mux : `GPA_ZERO;

	// function select, direction and output latch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			func_q  <= `GPA_RST_FUNC;
			dir_q   <= `GPA_RST_DIR;
			latch_q <= `GPA_RST_LATCH;
		end else begin
			if (wr_func)
				func_q <= cfg_req.wdata;
			if (wr_dir)
				dir_q <= cfg_req.wdata;
			if (wr_data)
				latch_q <= cfg_req.wdata;
		end
	end

	// read answer, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rsp_q <= '0;
		else
			rsp_q <= rsp_d;
	end

	// sample divider: one enable per sampling period
	assign sample_en = (div_q == `GPA_DIV_ZERO);
	assign div_d = sample_en ? `GPA_DIV_W'(`GPA_SAMPLE_CYC - 1)
	                         : div_q - `GPA_DIV_W'(1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			div_q <= `GPA_DIV_ZERO;
		else
			div_q <= div_d;
	end

	// two-flop synchroniser on all pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= `GPA_ZERO;
			sync2_q <= `GPA_ZERO;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// rate-limited level capture feeding the data register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			level_q <= `GPA_ZERO;
		else if (sample_en)
			level_q <= sync2_q;
	end

	// alternate output sources placed at their pin positions
	assign alt_drive[`GPA_EVENT_PIN-1:0] = '0;
	assign alt_drive[`GPA_EVENT_PIN] = event_out_n;
	assign alt_drive[`GPA_RST_PIN_HI:`GPA_RST_PIN_LO] =
		downstream_port_reset_out_n;
	assign alt_drive[31:`GPA_RST_PIN_HI+1] = '0;

	// pin driver: general output, alternate output or released
	assign gp_out_sel = ~func_q & dir_q;
	assign pad_d.out  = (func_q & alt_drive) | (gp_out_sel & latch_q);
	assign pad_d.oe   = (func_q & `GPA_ALT_OUT_MASK) | gp_out_sel;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pad_q <= '0;
		else
			pad_q <= pad_d;
	end

	// expander interrupts, held idle high unless the pin is alternate
	assign irq_d[7:0] = level_q[`GPA_IRQ_PIN_HI:`GPA_IRQ_PIN_LO] |
	                    ~func_q[`GPA_IRQ_PIN_HI:`GPA_IRQ_PIN_LO];
	assign irq_d[8]   = level_q[`GPA_IRQ10_PIN] |
	                    ~func_q[`GPA_IRQ10_PIN];

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq_q <= `GPA_IRQ_IDLE;
		else
			irq_q <= irq_d;
	end

	assign cfg_rsp           = rsp_q;
	assign pad               = pad_q;
	assign expander_irq_in_n = irq_q;

	// checks on the pin behaviour
	a_reset_all_input: assert property (
		@(posedge clk) $fell(rst) |-> (pad_q.oe == `GPA_ZERO &&
		                               irq_q == `GPA_IRQ_IDLE))
		else $error("pin driven or alternate active after reset");

	a_input_no_drive: assert property (
		@(posedge clk) disable iff (rst)
		1'b1 |=> ((pad_q.oe & ~($past(func_q) | $past(dir_q))) == '0))
		else $error("general input pin is driven");

	a_out_follows_latch: assert property (
		@(posedge clk) disable iff (rst)
		1'b1 |=> (((pad_q.out ^ $past(latch_q)) |
		           ~pad_q.oe) & $past(gp_out_sel)) == '0)
		else $error("general output pin does not drive latch value");

	a_event_pin_drive: assert property (
		@(posedge clk) disable iff (rst)
		func_q[`GPA_EVENT_PIN] |=> (pad_q.oe[`GPA_EVENT_PIN] &&
		    pad_q.out[`GPA_EVENT_PIN] == $past(event_out_n)))
		else $error("event pin does not carry event output");

	a_port_reset_drive: assert property (
		@(posedge clk) disable iff (rst)
		1'b1 |=> ((pad_q.out[`GPA_RST_PIN_HI:`GPA_RST_PIN_LO] ^
		           $past(downstream_port_reset_out_n)) &
		          $past(func_q[`GPA_RST_PIN_HI:`GPA_RST_PIN_LO])) == '0)
		else $error("port reset pin does not carry reset output");

	a_irq_held_idle: assert property (
		@(posedge clk) disable iff (rst)
		1'b1 |=> ((~irq_q[7:0] &
		           ~$past(func_q[`GPA_IRQ_PIN_HI:`GPA_IRQ_PIN_LO])) == '0 &&
		          (irq_q[8] || $past(func_q[`GPA_IRQ10_PIN]))))
		else $error("expander interrupt active on general pin");

	a_irq_follows_pin: assert property (
		@(posedge clk) disable iff (rst)
		func_q[`GPA_IRQ_PIN_HI] |=> (irq_q[7] ==
		    $past(level_q[`GPA_IRQ_PIN_HI])))
		else $error("expander interrupt does not follow pin");

	a_sample_rate_limit: assert property (
		@(posedge clk) disable iff (rst)
		$changed(level_q) |=> $stable(level_q))
		else $error("pin levels sampled faster than allowed");

	a_sample_sync_path: assert property (
		@(posedge clk) disable iff (rst)
		sample_en |=> (level_q == $past(pin_in, 3)))
		else $error("sampled level does not match synchronised pin");

	a_read_pin_level: assert property (
		@(posedge clk) disable iff (rst)
		(cfg_req.rd && cfg_req.sel == `GPA_REG_DATA)
		|=> (rsp_q.valid && rsp_q.rdata == $past(level_q)))
		else $error("data read does not return pin levels");

	a_write_latch_load: assert property (
		@(posedge clk) disable iff (rst)
		wr_data |=> (latch_q == $past(cfg_req.wdata)) ##1
		            ((pad_q.out & pad_q.oe & $past(gp_out_sel)) ==
		             ($past(latch_q) & pad_q.oe & $past(gp_out_sel))))
		else $error("data write does not load output latch");

	a_func_write: assert property (
		@(posedge clk) disable iff (rst)
		wr_func |=> (func_q == $past(cfg_req.wdata)))
		else $error("function select write lost");

	a_cfg_decode: assert property (
		@(posedge clk) disable iff (rst)
		(cfg_req.wr && cfg_req.sel == `GPA_REG_UNUSED) |=>
		($stable(func_q) && $stable(dir_q) && $stable(latch_q)))
		else $error("unused select changed a register");

endmodule : gpa_gpio_port

// ---- rtl/gpa_defs.svh ----
// register selects, pin map, reset values and timing for the gpio port
`ifndef GPA_DEFS_SVH
`define GPA_DEFS_SVH

`define GPA_NPINS          32
`define GPA_SEL_W          2
`define GPA_REG_FUNC       2'h0
`define GPA_REG_DIR        2'h1
`define GPA_REG_DATA       2'h2
`define GPA_REG_UNUSED     2'h3
`define GPA_RST_FUNC       32'h0000_0000
`define GPA_RST_DIR        32'h0000_0000
`define GPA_RST_LATCH      32'h0000_0000
`define GPA_ZERO           32'h0000_0000
`define GPA_ONES           32'hffff_ffff
`define GPA_ALT_OUT_MASK   32'h001f_ffe0
`define GPA_ALT_IN_MASK    32'h9fe0_0000
`define GPA_EVENT_PIN      5
`define GPA_RST_PIN_LO     6
`define GPA_RST_PIN_HI     20
`define GPA_IRQ_PIN_LO     21
`define GPA_IRQ_PIN_HI     28
`define GPA_IRQ10_PIN      31
`define GPA_IRQ_W          9
`define GPA_IRQ_IDLE       9'h1ff
`define GPA_SAMPLE_NS      128
`define GPA_CLK_NS         100
`define GPA_SAMPLE_CYC     ((`GPA_SAMPLE_NS + `GPA_CLK_NS - 1) / `GPA_CLK_NS)
`define GPA_DIV_W          2
`define GPA_DIV_ZERO       2'h0

`endif

// ---- rtl/gpa_pkg.sv ----
// packed carriers for the gpio port configuration access and pads
package gpa_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [1:0]  sel;
		logic [31:0] wdata;
	} gpa_cfg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} gpa_cfg_rsp_t;

	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
	} gpa_pad_t;

endpackage : gpa_pkg

// ---- testbench/gpa_board_model.sv ----
// board side of the pins: resolves each pad from port drive and sources
`timescale 1ns/1ps
module gpa_board_model (
	input  wire gpa_pkg::gpa_pad_t pad,
	input  wire logic [31:0]       ext,
	output      logic [31:0]       pin_in
);
	// a driven pin shows the port value, an undriven one the board source
	assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule : gpa_board_model

// ---- testbench/test_gpa_gpio_port.sv ----
// self-checking bench for the gpio port with a register and pin model
`timescale 1ns/1ps
`include "gpa_defs.svh"
module test_gpa_gpio_port;
	logic                  clk;
	logic                  rst;
	gpa_pkg::gpa_cfg_req_t cfg_req;
	gpa_pkg::gpa_cfg_rsp_t cfg_rsp;
	gpa_pkg::gpa_pad_t     pad;
	logic [31:0]           pin_in;
	logic [31:0]           ext;
	logic                  event_out_n;
	logic [15:1]           prst_n;
	logic [8:0]            irq_n;
	logic [31:0]           func_m, dir_m, lat_m, oe_x, out_x, pin_x, rv;
	int                    error_cnt, n_checks, r;

	gpa_gpio_port uut (.clk(clk), .rst(rst), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .pin_in(pin_in), .pad(pad),
		.event_out_n(event_out_n), .downstream_port_reset_out_n(prst_n),
		.expander_irq_in_n(irq_n));
	gpa_board_model board (.pad(pad), .ext(ext), .pin_in(pin_in));

	// expected enables, drive values and pin levels from the model
	assign oe_x  = (~func_m & dir_m) | (func_m & `GPA_ALT_OUT_MASK);
	assign out_x = (~func_m & lat_m)
		| (func_m & {11'h000, prst_n, event_out_n, 5'h00});
	assign pin_x = (oe_x & out_x) | (~oe_x & ext);

	always #50 clk = ~clk;

	task automatic summarize;
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t pin %h exp %h", $time, got, exp);
		end
	endtask : chk_pin

	// one-cycle write strobe launched off the falling edge, then one idle
	task automatic wr_reg(input logic [1:0] s, input logic [31:0] d);
		cfg_req.wr = 1'b1;
		cfg_req.sel = s;
		cfg_req.wdata = d;
		@(negedge clk);
		cfg_req.wr = 1'b0;
		@(negedge clk);
	endtask : wr_reg

	// read strobe, then a bounded wait for the answer
	task automatic rd_reg(input logic [1:0] s, output logic [31:0] d);
		int k;
		cfg_req.rd = 1'b1;
		cfg_req.sel = s;
		@(negedge clk);
		cfg_req.rd = 1'b0;
		for (k = 0; k < 4 && cfg_rsp.valid !== 1'b1; k++) @(negedge clk);
		if (cfg_rsp.valid !== 1'b1) begin
			error_cnt++;
			$display("wrong value at %0t valid %h exp %h", $time,
			         cfg_rsp.valid, 1'b1);
		end
		d = cfg_rsp.rdata;
		@(negedge clk);
	endtask : rd_reg

	// compare every pad, interrupt and register view with the model
	task automatic check_all;
		logic [31:0] t;
		repeat (8) @(negedge clk);
		t = ~func_m | pin_x;
		chk_pin(pad.oe, oe_x);
		chk_pin(pad.out & oe_x, out_x & oe_x);
		chk_pin({23'h0, irq_n}, {23'h0, t[31], t[28:21]});
		rd_reg(`GPA_REG_FUNC, rv);
		chk_reg(rv, func_m);
		rd_reg(`GPA_REG_DIR, rv);
		chk_reg(rv, dir_m);
		rd_reg(`GPA_REG_DATA, rv);
		chk_reg(rv, pin_x);
		rd_reg(`GPA_REG_UNUSED, rv);
		chk_reg(rv, `GPA_ZERO);
	endtask : check_all

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cfg_req = '0;
		ext = 32'h0000_0000;
		event_out_n = 1'b1;
		prst_n = 15'h7fff;
		func_m = `GPA_RST_FUNC;
		dir_m = `GPA_RST_DIR;
		lat_m = `GPA_RST_LATCH;
		error_cnt = 0;
		n_checks = 0;
		void'($urandom(96));
		repeat (12) @(negedge clk);
		rst = 1'b0;
		ext = $urandom;
		check_all();
		for (r = 0; r < 8; r++) begin
			func_m = (r == 7) ? `GPA_ONES : (r < 2) ? `GPA_ZERO : $urandom;
			dir_m = (r == 0) ? `GPA_ZERO : $urandom;
			lat_m = $urandom;
			wr_reg(`GPA_REG_FUNC, func_m);
			wr_reg(`GPA_REG_DIR, dir_m);
			wr_reg(`GPA_REG_DATA, lat_m);
			wr_reg(`GPA_REG_UNUSED, $urandom);
			rv = $urandom;
			event_out_n = rv[0];
			prst_n = rv[15:1];
			ext = $urandom;
			check_all();
		end
		summarize();
	end
endmodule : test_gpa_gpio_port
